/* File: bench/output_clock_realign_sync_tb.sv */
// Bench for strobe realign, calibration and code clipping.
// Assumes the controller model drives the realign pulse.
`timescale 1ns/1ps
`default_nettype none
module output_clock_realign_sync_tb;
    logic        mclk_i = 1'b0, rst_i = 1'b1, ddr = 1'b0, esel = 1'b0, req = 1'b0, cal_go = 1'b0, ce = 1'b1;
    logic        realign, cal_act, over, strobe;
    logic [3:0]  len = 4'h6;
    logic [7:0]  cal_len = 8'h05, code_a, code_b;
    logic [9:0]  raw_a = 10'h000, raw_b = 10'h000;
    logic [9:0]  tbl [7] = '{10'h37F, 10'h380, 10'h07F, 10'h080, 10'h000, 10'h200, 10'h1FF};
    logic [31:0] lfsr = 32'hF6FB2039;
    logic [16:0] q [$];
    int          n_errors = 0, n_tests = 0, cyc = 0;
    always #12.5 mclk_i = ~mclk_i;
    realign_ctrl_model ctrl (.mclk_i(mclk_i), .calibration_active_i(cal_act), .req_i(req), .len_i(len),
        .strobe_realign_in_o(realign));
    output_clock_realign_sync uut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .ddr_mode_i(ddr),
        .edge_sel_i(esel), .strobe_realign_in_i(realign), .cal_start_i(cal_go), .cal_len_i(cal_len),
        .calibration_active_o(cal_act), .raw_a_i(raw_a), .raw_b_i(raw_b), .code_a_o(code_a),
        .code_b_o(code_b), .over_range_o(over), .output_strobe_o(strobe));
    function automatic logic [8:0] clip(input logic signed [9:0] r);
        int s;
        s = int'(r) + 128;
        if (s < 0)
            return 9'h100;
        if (s > 255)
            return 9'h1FF;
        return {1'b0, 8'(s)};
    endfunction : clip
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : lfsr_next
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("errors %0d, checks %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic step;
        @(posedge mclk_i) #1;
    endtask : step
    task automatic put(input logic [9:0] a, input logic [9:0] b);
        logic [8:0] ea, eb;
        raw_a = a;
        raw_b = b;
        ea = clip(a);
        eb = clip(b);
        step();
        q.push_back({ea[8] | eb[8], ea[7:0], eb[7:0]});
    endtask : put
    task automatic realign_run(input logic d, input logic e);
        logic h;
        int   t;
        ddr = d;
        esel = e;
        h = d ? ~e : e;
        repeat (3) step();
        req = 1'b1;
        step();
        req = 1'b0;
        repeat (4) step();
        check(17'(strobe), 17'(h));
        repeat (2) step();
        check(17'(strobe), 17'(h));
        t = 0;
        while (strobe === h && t < 12) begin
            step();
            t++;
        end
        check(17'(t), 17'(strobe_realign_pkg::LATENCY_CYC) + (d ? 17'h3 : 17'h4));
        step();
        check(17'(strobe), {16'h0000, h});
        step();
        check(17'(strobe), {16'h0000, ~h});
    endtask : realign_run
    task automatic freeze_run;
        ce = 1'b0;
        raw_a = 10'h1FF;
        raw_b = 10'h200;
        repeat (3) step();
        check({over, code_a, code_b}, 17'h08080);
        ce = 1'b1;
        raw_a = 10'h000;
        raw_b = 10'h000;
    endtask : freeze_run
    task automatic cal_run;
        int t;
        t = 0;
        cal_go = 1'b1;
        step();
        cal_go = 1'b0;
        req = 1'b1;
        repeat (20) begin
            if (cal_act === 1'b1) begin
                t++;
                check(17'(strobe | realign), 17'h0);
            end
            step();
            req = 1'b0;
        end
        check(17'(t), 17'(cal_len) + 17'h1);
    endtask : cal_run
    always @(negedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            n_errors++;
            stop_test();
        end
        if (q.size() > 0)
            check({over, code_a, code_b}, q.pop_front());
    end
    initial begin
        repeat (4) step();
        rst_i = 1'b0;
        foreach (tbl[i])
            put(tbl[i], tbl[6 - i]);
        repeat (40) begin
            lfsr = lfsr_next(lfsr);
            put(lfsr[9:0], lfsr[25:16]);
        end
        put(10'h000, 10'h000);
        freeze_run();
        for (int m = 0; m < 4; m++)
            realign_run(m[1], m[0]);
        cal_run();
        stop_test();
    end
endmodule : output_clock_realign_sync_tb
`default_nettype wire

/* File: bench/realign_ctrl_model.sv */
// Controller model: raises the realign pulse off the clock grid.
// Assumes req_i is a one-cycle pulse from the bench.
`timescale 1ns/1ps
`default_nettype none
module realign_ctrl_model (
    // Clock and status
    input  wire logic       mclk_i,
    input  wire logic       calibration_active_i,
    // Bench request
    input  wire logic       req_i,
    input  wire logic [3:0] len_i,
    // Realign pulse
    output logic            strobe_realign_in_o
);
    logic [3:0] cnt = 4'h0;
    initial strobe_realign_in_o = 1'b0;
    always @(posedge mclk_i) begin
        if (req_i && !calibration_active_i) begin
            cnt <= len_i;
            strobe_realign_in_o <= #7 1'b1;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1)
                strobe_realign_in_o <= 1'b0;
        end
    end
endmodule : realign_ctrl_model
`default_nettype wire

/* File: logic/code_clip.sv */
// Offset-binary code clipping and over-range detection for one bus.
// Assumes a signed two's complement raw result centred on midscale.
`timescale 1ns/1ps
`default_nettype none
module code_clip (
    // Clock and control
    input  wire logic                                mclk_i,
    input  wire logic                                rst_i,
    input  wire logic                                ce_i,
    // Raw signed result
    input  wire logic signed [strobe_realign_pkg::RAW_W-1:0]  raw_i,
    // Clipped code and flag
    output logic        [strobe_realign_pkg::CODE_W-1:0] code_o,
    output logic                                     over_o
);
    logic signed [strobe_realign_pkg::RAW_W:0] biased;
    // Extra bit keeps the biased sum from wrapping at the ends of the raw range
    assign biased = $signed({raw_i[strobe_realign_pkg::RAW_W-1], raw_i}) + 11'sh080;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            code_o <= strobe_realign_pkg::CODE_RST;
            over_o <= 1'b0;
        end else if (ce_i) begin
            // RQ9 saturate at ends
            if (biased < 11'sh000) begin
                code_o <= strobe_realign_pkg::CODE_MIN;
                over_o <= 1'b1;
            end else if (biased > 11'sh0FF) begin
                code_o <= strobe_realign_pkg::CODE_MAX;
                over_o <= 1'b1;
            end else begin
                // RQ8 offset binary code
                code_o <= biased[7:0];
                over_o <= 1'b0;
            end
        end
    end
endmodule : code_clip
`default_nettype wire

/* File: logic/output_clock_realign_sync.sv */
// Output strobe realignment, calibration gating and output code clipping.
// Assumes the realign pulse is released on a rising clock edge by the controller.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1 - Realign assertion is accepted at any moment without qualification.
// RQ2 - During realign the strobe holds a level set by rate and edge mode.
// RQ3 - A shortened strobe pulse may appear when realign cuts a period.
// RQ4 - Controller releases realign on a rising edge of the sample clock.
// RQ5 - First falling edge after release restarts the strobe phase.
// RQ6 - Strobe resumes after the normal clock to strobe latency.
// RQ7 - Controller never asserts realign while calibration is active.
// RQ8 - Output codes are 8-bit offset binary, midscale at 7Fh/80h.
// RQ9 - Out of range inputs saturate at the nearest end code.
// RQ10 - Over-range flag is active exactly while the signal is out of range.
// RQ11 - Over-range flag is set if either bus falls outside 00h to FFh.
// RQ12 - Calibration flag high for whole cycle; strobe inactive meanwhile.
module output_clock_realign_sync (
    // Clock, reset, enable
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Mode controls
    input  wire logic        ddr_mode_i,
    input  wire logic        edge_sel_i,
    // Realign and calibration
    input  wire logic        strobe_realign_in_i,
    input  wire logic        cal_start_i,
    input  wire logic [7:0]  cal_len_i,
    output logic             calibration_active_o,
    // Raw results of both buses
    input  wire logic [9:0]  raw_a_i,
    input  wire logic [9:0]  raw_b_i,
    // Outputs
    output logic [7:0]       code_a_o,
    output logic [7:0]       code_b_o,
    output logic             over_range_o,
    output logic             output_strobe_o
);
    // RUN toggles the strobe, HOLD pins it while realign is high,
    // WAIT_FALL waits for the falling-edge marker and LATENT counts out
    // the normal clock to strobe delay before toggling resumes
    typedef enum logic [1:0] {RUN, HOLD, WAIT_FALL, LATENT} phase_e;
    phase_e     phase;
    logic [3:0] lat_cnt;
    logic [7:0] cal_cnt;
    logic       div;
    logic       fall_seen;
    logic       over_a;
    logic       over_b;
    logic       cal_begin;

    function automatic logic hold_level(input logic ddr, input logic edge_sel);
        hold_level = ddr ? ~edge_sel : edge_sel;
    endfunction : hold_level

    // Falling edge marker, sampled once per clock: set after a realign release
    // Living on the falling edge lines the restart up with every sibling
    // converter released on the same rising edge
    always_ff @(negedge mclk_i) begin
        if (rst_i) begin
            fall_seen <= 1'b0;
        end else if (ce_i) begin
            // RQ5 falling edge restart
            fall_seen <= (phase == WAIT_FALL);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            phase   <= RUN;
            lat_cnt <= 4'h0;
        end else if (ce_i) begin
            case (phase)
                RUN: begin
                    // RQ1 unqualified assertion
                    if (strobe_realign_in_i) begin
                        phase <= HOLD;
                    end
                end
                HOLD: begin
                    // RQ4 release on rising edge
                    if (!strobe_realign_in_i) begin
                        phase <= WAIT_FALL;
                    end
                end
                WAIT_FALL: begin
                    if (strobe_realign_in_i) begin
                        phase <= HOLD;
                    end else if (fall_seen) begin
                        phase   <= LATENT;
                        lat_cnt <= 4'h1;
                    end
                end
                LATENT: begin
                    // RQ6 normal latency
                    if (strobe_realign_in_i) begin
                        phase <= HOLD;
                    end else if (lat_cnt >= strobe_realign_pkg::LATENCY_CYC) begin
                        phase <= RUN;
                    end else begin
                        lat_cnt <= lat_cnt + 4'h1;
                    end
                end
                default: phase <= RUN;
            endcase
        end
    end

    // Start is refused while realign is high or a cycle is running
    assign cal_begin = !calibration_active_o && cal_start_i && !strobe_realign_in_i;

    // RQ12 calibration cycle
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            calibration_active_o <= 1'b0;
            cal_cnt              <= 8'h00;
        end else if (ce_i) begin
            // RQ7 start refused while realign is high
            if (cal_begin) begin
                calibration_active_o <= 1'b1;
                cal_cnt              <= cal_len_i;
            end else if (calibration_active_o) begin
                if (cal_cnt == 8'h00) begin
                    calibration_active_o <= 1'b0;
                end else begin
                    cal_cnt <= cal_cnt - 8'h01;
                end
            end
        end
    end

    // Strobe divider; realign may cut it short mid-period
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            div             <= strobe_realign_pkg::STROBE_RST;
            output_strobe_o <= strobe_realign_pkg::STROBE_RST;
        end else if (ce_i) begin
            // RQ12 quiet from the start edge
            if (calibration_active_o || cal_begin) begin
                output_strobe_o <= 1'b0;
                div             <= 1'b0;
            // RQ2 RQ3 held level
            end else if (strobe_realign_in_i || phase != RUN) begin
                output_strobe_o <= hold_level(ddr_mode_i, edge_sel_i);
                div             <= 1'b0;
            end else begin
                div             <= ~div;
                output_strobe_o <= ddr_mode_i ? ~output_strobe_o : (div ^ edge_sel_i);
            end
        end
    end

    code_clip u_clip_a (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .raw_i  (raw_a_i),
        .code_o (code_a_o),
        .over_o (over_a)
    );
    code_clip u_clip_b (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .raw_i  (raw_b_i),
        .code_o (code_b_o),
        .over_o (over_b)
    );
    // RQ10 RQ11 either bus out of range
    assign over_range_o = over_a | over_b;

    hold_level_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ2
        ce_i && strobe_realign_in_i && !calibration_active_o
        |=> output_strobe_o == hold_level($past(ddr_mode_i), $past(edge_sel_i)))
        else $error("strobe not held during realign");
    cal_quiet_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ12
        ce_i && calibration_active_o |=> !output_strobe_o)
        else $error("strobe active during calibration");
    clip_high_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ9
        ce_i && $signed(raw_a_i) > 10'sh07F |=> code_a_o == 8'hFF && over_range_o)
        else $error("high clip missing");
    clip_low_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ9
        ce_i && $signed(raw_a_i) < -10'sh080 |=> code_a_o == 8'h00)
        else $error("low clip missing");
    mid_code_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ8
        ce_i && raw_a_i == 10'h000 |=> code_a_o == 8'h80)
        else $error("midscale code wrong");
    in_range_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ10
        ce_i && $signed(raw_a_i) inside {[-128:127]} && $signed(raw_b_i) inside {[-128:127]}
        |=> !over_range_o)
        else $error("flag set in range");
    either_bus_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ11
        ce_i && $signed(raw_b_i) > 10'sh07F |=> over_range_o)
        else $error("bus b range not flagged");
    resume_lat_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ6
        phase == HOLD && !strobe_realign_in_i && ce_i ##1 ce_i [*8]
        |-> phase == RUN || strobe_realign_in_i)
        else $error("strobe did not resume");

    // Strobe sequencing checks
    realign_enter_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ1
        ce_i && strobe_realign_in_i |=> phase == HOLD)
        else $error("realign not taken");
    restart_fall_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ5
        ce_i && phase == WAIT_FALL && !strobe_realign_in_i |=> phase == LATENT)
        else $error("no restart on falling edge");
    latent_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ6
        ce_i && phase == LATENT && !calibration_active_o && !cal_begin
        |=> output_strobe_o == hold_level($past(ddr_mode_i), $past(edge_sel_i)))
        else $error("strobe moved during latency");
    ddr_toggle_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ6
        ce_i && phase == RUN && ddr_mode_i && !strobe_realign_in_i && !calibration_active_o && !cal_begin
        |=> output_strobe_o != $past(output_strobe_o))
        else $error("strobe stalled in run");
    cal_start_a: assert property (@(posedge mclk_i) disable iff (rst_i) // RQ12
        ce_i && cal_begin |=> calibration_active_o && !output_strobe_o)
        else $error("calibration start not quiet");

    // Scenario covers
    realign_c: cover property (@(posedge mclk_i) phase == LATENT ##[1:8] phase == RUN);
    cal_c: cover property (@(posedge mclk_i) $fell(calibration_active_o));
    over_c: cover property (@(posedge mclk_i) $rose(over_range_o));
    ddr_realign_c: cover property (@(posedge mclk_i) ddr_mode_i && phase == HOLD);
    sdr_realign_c: cover property (@(posedge mclk_i) !ddr_mode_i && phase == HOLD);
endmodule : output_clock_realign_sync
`default_nettype wire

/* File: logic/strobe_realign_pkg.sv */
// Shared constants for the output strobe realign and code clipping logic.
// Assumes one sample clock; all inputs synchronous to it.
package strobe_realign_pkg;
    localparam int  CODE_W        = 8;
    localparam int  RAW_W         = 10;
    localparam logic [7:0] CODE_MIN = 8'h00;
    localparam logic [7:0] CODE_MAX = 8'hFF;
    localparam logic [7:0] CODE_RST = 8'h80;
    // Normal clock to strobe delay, in ns, and its count of cycles at 40 MHz
    localparam int  CLK_PERIOD_PS = 25000;
    localparam int  LATENCY_NS    = 75;
    localparam int  LATENCY_CYC_I = ((LATENCY_NS * 1000) / CLK_PERIOD_PS) < 1 ? 1
                                    : ((LATENCY_NS * 1000) / CLK_PERIOD_PS);
    localparam logic [3:0] LATENCY_CYC = 4'(LATENCY_CYC_I);
    localparam logic       STROBE_RST  = 1'b0;
    localparam logic [9:0] RAW_RST     = 10'h000;
endpackage : strobe_realign_pkg
